// >>> logic/rtc_serial_host.sv
// Purpose: two-wire bus host doing byte writes and random sequential reads
// Assumes: one slave, push-pull clock, open-drain data with external pull-up
// Notes: read bytes land in an 8-deep FIFO; a full FIFO stretches the clock
`timescale 1ns/10ps
`default_nettype none
module rtc_serial_host (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // serial pins
  output logic SCL_OUT,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // command
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_READ,
  input wire logic [7:0] CMD_WORD,
  input wire logic [7:0] CMD_WDATA,
  input wire logic [7:0] CMD_COUNT,
  // status
  output logic DONE,
  output logic NACK,
  // read data
  output logic RD_VALID,
  input wire logic RD_READY,
  output logic [rtc_host_pkg::DATA_W-1:0] RD_DATA
);
  import rtc_host_pkg::*;

  state_t state_ff, nxt_state;
  kind_t kind_ff, nxt_kind;
  logic [1:0] phase_ff, nxt_phase;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift, left_ff, nxt_left;
  logic [7:0] word_ff, nxt_word, wdata_ff, nxt_wdata;
  logic read_ff, nxt_read, ack_bad_ff, nxt_ack_bad;
  logic scl_ff, nxt_scl, sda_oe_ff, nxt_sda_oe;
  logic done_ff, nxt_done, nack_ff, nxt_nack, cmd_ready_ff, nxt_cmd_ready;
  logic [PWR_W-1:0] pwr_ff, nxt_pwr;
  logic [QCNT_W-1:0] qcnt_ff;
  logic tick_ff, sda_meta_ff, sda_s_ff, stall;

  stream_if #(.W(DATA_W)) push_if ();

  // ---------------------------------------------------------------
  // read buffer
  // ---------------------------------------------------------------
  byte_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(CLOCK),
    .rst_b(RST_B),
    .push(push_if),
    .out_valid(RD_VALID),
    .out_ready(RD_READY),
    .out_data(RD_DATA)
  );

  // ---------------------------------------------------------------
  // quarter-period divider and input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      qcnt_ff <= '0;
      tick_ff <= 1'b0;
      sda_meta_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      qcnt_ff <= (qcnt_ff == QCNT_LAST) ? '0 : QCNT_W'(qcnt_ff + 1'b1);
      tick_ff <= (qcnt_ff == QCNT_LAST);
      sda_meta_ff <= SDA_IN;
      sda_s_ff <= sda_meta_ff;
    end
  end

  // value put on the data line for a bit of a byte; 1 means pull low
  function automatic logic pull_low(kind_t k, logic [3:0] b, logic [7:0] s, logic [7:0] l);
    logic r;
    r = 1'b0;
    if (b == ACK_BIT) begin
      r = (k == K_RDATA) && (l > 8'h01);
    end else if (k != K_RDATA) begin
      r = !s[7];
    end
    return r;
  endfunction

  // a full buffer holds the clock low before the next read byte
  assign stall = (kind_ff == K_RDATA) && (bit_ff == 4'h0) && (phase_ff == 2'h0) && !push_if.ready;
  assign push_if.data = shift_ff;

  // ---------------------------------------------------------------
  // transaction sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_phase = phase_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_left = left_ff;
    nxt_word = word_ff;
    nxt_wdata = wdata_ff;
    nxt_read = read_ff;
    nxt_ack_bad = ack_bad_ff;
    nxt_scl = scl_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_done = 1'b0;
    nxt_nack = nack_ff;
    nxt_pwr = pwr_ff;
    push_if.valid = 1'b0;
    unique case (state_ff)
      ST_PWRUP: begin
        // wait out the device power-up before the first start
        if (pwr_ff == PWR_LAST) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_pwr = PWR_W'(pwr_ff + 1'b1);
        end
      end
      ST_IDLE: begin
        if (CMD_VALID && cmd_ready_ff) begin
          nxt_read = CMD_READ;
          nxt_word = CMD_WORD;
          nxt_wdata = CMD_WDATA;
          nxt_left = (CMD_COUNT == 8'h00) ? 8'h01 : CMD_COUNT;
          nxt_kind = K_IDW;
          nxt_phase = 2'h0;
          nxt_nack = 1'b0;
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        // low-release, high-release, high-low, then into the first bit
        if (tick_ff) begin
          nxt_phase = 2'(phase_ff + 1'b1);
          nxt_scl = (nxt_phase != 2'h0);
          nxt_sda_oe = (nxt_phase >= PH_SAMPLE);
          if (phase_ff == PH_LAST) begin
            nxt_state = ST_BYTE;
            nxt_bit = 4'h0;
            nxt_scl = 1'b0;
            nxt_shift = (kind_ff == K_IDR) ? {DEV_ID, RW_READ} : {DEV_ID, RW_WRITE};
            nxt_sda_oe = pull_low(kind_ff, 4'h0, nxt_shift, left_ff);
          end
        end
      end
      ST_BYTE: begin
        if (tick_ff && !stall) begin
          nxt_phase = 2'(phase_ff + 1'b1);
          nxt_scl = nxt_phase[1]; // low in quarters 0 and 1, high in 2 and 3, data set in low half
          if (phase_ff == PH_SAMPLE) begin
            if (kind_ff == K_RDATA && bit_ff != ACK_BIT) begin
              nxt_shift = {shift_ff[6:0], sda_s_ff};
            end
            if (kind_ff != K_RDATA && bit_ff == ACK_BIT) begin
              nxt_ack_bad = sda_s_ff;
            end
          end
          if (phase_ff == PH_LAST) begin
            nxt_bit = 4'(bit_ff + 1'b1);
            if (kind_ff != K_RDATA && bit_ff != ACK_BIT) begin
              nxt_shift = {shift_ff[6:0], 1'b0};
            end
            if (bit_ff == ACK_BIT) begin
              nxt_bit = 4'h0;
              if (kind_ff != K_RDATA && ack_bad_ff) begin
                nxt_nack = 1'b1;
                nxt_state = ST_STOP;
              end else begin
                unique case (kind_ff)
                  K_IDW: begin
                    nxt_kind = K_WORD;
                    nxt_shift = word_ff;
                  end
                  K_WORD: begin
                    if (read_ff) begin
                      nxt_kind = K_IDR;
                      nxt_state = ST_START;
                    end else begin
                      nxt_kind = K_WDATA;
                      nxt_shift = wdata_ff;
                    end
                  end
                  K_WDATA: nxt_state = ST_STOP;
                  K_IDR: nxt_kind = K_RDATA;
                  K_RDATA: begin
                    push_if.valid = 1'b1;
                    if (left_ff > 8'h01) begin
                      nxt_left = 8'(left_ff - 1'b1);
                    end else begin
                      nxt_state = ST_STOP;
                    end
                  end
                endcase
              end
            end
            if (nxt_state == ST_BYTE) begin
              nxt_sda_oe = pull_low(nxt_kind, nxt_bit, nxt_shift, nxt_left);
            end else begin
              nxt_sda_oe = (nxt_state == ST_STOP); // restart releases, stop pulls low
            end
          end
        end
      end
      ST_STOP: begin
        // low-low, high-low, high-release, then idle
        if (tick_ff) begin
          nxt_phase = 2'(phase_ff + 1'b1);
          nxt_scl = 1'b1;
          nxt_sda_oe = (nxt_phase == 2'h1);
          if (phase_ff == PH_LAST) begin
            nxt_state = ST_IDLE;
            nxt_done = 1'b1;
          end
        end
      end
    endcase
    nxt_cmd_ready = (nxt_state == ST_IDLE) && !(state_ff == ST_IDLE && CMD_VALID && cmd_ready_ff);
  end

  // sequencer registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      state_ff <= ST_PWRUP;
      kind_ff <= K_IDW;
      phase_ff <= 2'h0;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      left_ff <= 8'h01;
      word_ff <= 8'h00;
      wdata_ff <= 8'h00;
      read_ff <= 1'b0;
      ack_bad_ff <= 1'b0;
      scl_ff <= 1'b1;
      sda_oe_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      pwr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      phase_ff <= nxt_phase;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      left_ff <= nxt_left;
      word_ff <= nxt_word;
      wdata_ff <= nxt_wdata;
      read_ff <= nxt_read;
      ack_bad_ff <= nxt_ack_bad;
      scl_ff <= nxt_scl;
      sda_oe_ff <= nxt_sda_oe;
      done_ff <= nxt_done;
      nack_ff <= nxt_nack;
      cmd_ready_ff <= nxt_cmd_ready;
      pwr_ff <= nxt_pwr;
    end
  end

  // pin and status outputs
  assign SCL_OUT = scl_ff;
  assign SDA_OE = sda_oe_ff;
  assign SDA_OUT = 1'b0; // open drain: only ever pulls low
  assign DONE = done_ff;
  assign NACK = nack_ff;
  assign CMD_READY = cmd_ready_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_byte_end;
    state_ff == ST_BYTE && bit_ff == ACK_BIT && phase_ff == PH_LAST && tick_ff;
  endsequence
  sequence s_ack_ok(kind_t k);
    s_byte_end ##0 (kind_ff == k && !ack_bad_ff);
  endsequence

  property p_data_steady;
    @(posedge CLOCK) disable iff (!RST_B)
      (state_ff == ST_BYTE && scl_ff && $past(scl_ff)) |-> $stable(sda_oe_ff);
  endproperty
  a_data_steady: assert property (p_data_steady) else $error("data moved while clock high");

  property p_msb_first;
    @(posedge CLOCK) disable iff (!RST_B)
      (state_ff == ST_BYTE && kind_ff != K_RDATA && bit_ff != ACK_BIT && phase_ff == 2'h1)
      |-> sda_oe_ff == !shift_ff[7];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("transmit bit not shift msb");

  property p_release_ack;
    @(posedge CLOCK) disable iff (!RST_B)
      (state_ff == ST_BYTE && kind_ff != K_RDATA && bit_ff == ACK_BIT) |-> !sda_oe_ff;
  endproperty
  a_release_ack: assert property (p_release_ack) else $error("line held in ack slot");

  property p_host_ack;
    @(posedge CLOCK) disable iff (!RST_B)
      (state_ff == ST_BYTE && kind_ff == K_RDATA && bit_ff == ACK_BIT && phase_ff == 2'h1)
      |-> sda_oe_ff == (left_ff > 8'h01);
  endproperty
  a_host_ack: assert property (p_host_ack) else $error("wrong host acknowledge");

  property p_dir_bit;
    @(posedge CLOCK) disable iff (!RST_B)
      (state_ff == ST_BYTE && bit_ff == 4'h7 && phase_ff == 2'h1 && (kind_ff == K_IDR || kind_ff == K_IDW))
      |-> sda_oe_ff == (kind_ff == K_IDW);
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("direction bit wrong");

  property p_word_follows;
    @(posedge CLOCK) disable iff (!RST_B)
      s_ack_ok(K_IDW) |=> (kind_ff == K_WORD && shift_ff == word_ff);
  endproperty
  a_word_follows: assert property (p_word_follows) else $error("word byte not next");

  property p_write_stops;
    @(posedge CLOCK) disable iff (!RST_B)
      s_ack_ok(K_WDATA) |=> state_ff == ST_STOP ##[1:600] (state_ff == ST_IDLE && DONE);
  endproperty
  a_write_stops: assert property (p_write_stops) else $error("write did not stop");

  property p_restart;
    @(posedge CLOCK) disable iff (!RST_B)
      s_ack_ok(K_WORD) ##0 read_ff |=> (state_ff == ST_START && kind_ff == K_IDR);
  endproperty
  a_restart: assert property (p_restart) else $error("no repeated start for read");

  property p_stop_edge;
    @(posedge CLOCK) disable iff (!RST_B)
      (state_ff == ST_STOP && phase_ff == 2'h1 && tick_ff) |=> (scl_ff && !sda_oe_ff);
  endproperty
  a_stop_edge: assert property (p_stop_edge) else $error("stop edge missing");
endmodule
`default_nettype wire

// >>> inc/rtc_host_pkg.sv
// Purpose: constants and types for the serial host that drives the clock chip
// Assumes: 200 MHz system clock, 400 kHz serial clock
// Notes: identifier value is arbitrary, set it to the fitted part
//
// Notes on behaviour
// - every byte on the line is shifted most significant bit first
// - data line changes only while clock is low, except start and stop
// - each transaction ends with a stop; device then goes to standby
// - sender releases data after bit eight; receiver pulls low on ninth clock
// - host acknowledges each read byte when it wants another
// - last bit of the first byte: one reads, zero writes
// - one word-address byte follows the identifier and selects the location
// - host sends the same identifier in dummy write and read phases
// - write is start, identifier, address, one data byte, stop
// - read is start, id write, address, repeated start, id read
// - device sends bytes while host acknowledges; host ends with stop
package rtc_host_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SCL_KHZ = 400;
  localparam int QUARTER_CYCLES = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
  localparam int PWRUP_NS = 1000;
  localparam int PWRUP_CYCLES = (PWRUP_NS * CLK_MHZ + 999) / 1000;
  localparam int QCNT_W = 8;
  localparam int PWR_W = 10;
  localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(QUARTER_CYCLES - 1);
  localparam logic [PWR_W-1:0] PWR_LAST = PWR_W'(PWRUP_CYCLES - 1);
  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV_ID = 7'h2A; // arbitrary value
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 8;
  typedef enum logic [2:0] {K_IDW, K_WORD, K_WDATA, K_IDR, K_RDATA} kind_t;
  typedef enum logic [2:0] {ST_PWRUP, ST_IDLE, ST_START, ST_BYTE, ST_STOP} state_t;
endpackage

// >>> inc/stream_if.sv
// Purpose: valid/ready byte stream between host engine and read buffer
// Assumes: one clock domain
// Notes: source holds data while valid and not ready
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> logic/byte_fifo.sv
// Purpose: flip-flop FIFO for read bytes
// Assumes: push and pop on the same clock
// Notes: ready drops when full, stalling the serial engine
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // filling side
  stream_if.snk push,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic [W-1:0] head_ff, nxt_head;
  logic valid_ff, nxt_valid;
  logic do_push, do_pop;

  // full from the fill count; head and valid leave from flops
  assign push.ready = (count_ff != (AW+1)'(D));
  assign out_valid = valid_ff;
  assign out_data = head_ff;
  assign do_push = push.valid && push.ready;
  assign do_pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    if (do_push) begin
      nxt_wr_ptr = (wr_ptr_ff == AW'(D - 1)) ? '0 : AW'(wr_ptr_ff + 1'b1);
    end
    if (do_pop) begin
      nxt_rd_ptr = (rd_ptr_ff == AW'(D - 1)) ? '0 : AW'(rd_ptr_ff + 1'b1);
    end
    if (do_push && !do_pop) begin
      nxt_count = (AW+1)'(count_ff + 1'b1);
    end else if (do_pop && !do_push) begin
      nxt_count = (AW+1)'(count_ff - 1'b1);
    end
    nxt_valid = (nxt_count != '0);
    // a push into the slot that becomes head bypasses the array
    nxt_head = (do_push && (wr_ptr_ff == nxt_rd_ptr)) ? push.data : mem_ff[nxt_rd_ptr];
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      head_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      head_ff <= nxt_head;
      valid_ff <= nxt_valid;
    end
  end

  // storage, written only on accepted push
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= push.data;
    end
  end
endmodule
`default_nettype wire

// >>> tb/rtc_dev_model.sv
// Purpose: behavioural clock-chip slave on the two-wire bus, the far side of the host
// Assumes: sampled on the system clock; data line has a pull-up, so release reads high
// Notes: map holds 26 bytes at 8'h30 plus the location; identifier comes from a port
`timescale 1ns/10ps
`default_nettype none
module rtc_dev_model (
  // sampling clock
  input wire logic clk,
  // bus lines as seen on the wire
  input wire logic scl,
  input wire logic sda,
  // identifier this part answers to
  input wire logic [6:0] dev_id,
  // data pull-down enable
  output logic oe
);
  // -----------------------------------------------------------
  // state
  // -----------------------------------------------------------
  logic [7:0] mem [0:25];
  logic scl_q = 1'b1, sda_q = 1'b1, active = 1'b0, tx_mode = 1'b0, m_ack = 1'b0, rw = 1'b0;
  logic [3:0] bitcnt = 4'h0;
  logic [1:0] byte_idx = 2'h0;
  logic [7:0] shreg = 8'h00, txb = 8'h00;
  logic [7:0] ptr = 8'h00;
  int age = 0;
  // power-up contents, driver released
  initial begin
    oe = 1'b0;
    for (int i = 0; i < 26; i++) mem[i] = 8'h30 + 8'(i);
  end
  // -----------------------------------------------------------
  // edge-driven slave engine
  // -----------------------------------------------------------
  always @(posedge clk) begin
    age <= age + 1;
    if (scl && scl_q && sda_q && !sda && age > 100) begin
      active = 1'b1;
      tx_mode = 1'b0;
      bitcnt = 4'hF; // the clock fall that closes a start is not a bit
      byte_idx = 2'h0;
      oe <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      active = 1'b0;
      tx_mode = 1'b0;
      oe <= 1'b0;
    end else if (active && scl && !scl_q) begin
      if (!tx_mode && bitcnt < 4'h8) shreg = {shreg[6:0], sda};
      if (tx_mode && bitcnt == 4'h8) m_ack = !sda;
    end else if (active && !scl && scl_q) begin
      if (bitcnt == 4'h7) begin
        bitcnt = 4'h8;
        oe <= 1'b0;
        if (!tx_mode) begin
          if (byte_idx == 2'h0 && shreg[7:1] != dev_id) begin
            active = 1'b0;
          end else begin
            oe <= 1'b1;
            if (byte_idx == 2'h0) rw = shreg[0];
            else if (byte_idx == 2'h1) ptr = shreg;
            else mem[ptr] = shreg;
          end
        end
      end else if (bitcnt == 4'h8) begin
        bitcnt = 4'h0;
        oe <= 1'b0;
        if (byte_idx != 2'h3) byte_idx = byte_idx + 2'h1;
        if ((tx_mode && m_ack) || (!tx_mode && byte_idx == 2'h1 && rw)) begin
          tx_mode = 1'b1;
          txb = mem[ptr];
          oe <= !txb[7];
          ptr = (ptr == 8'h19) ? 8'h00 : ptr + 8'h01;
        end else if (tx_mode) begin
          active = 1'b0;
        end
      end else begin
        bitcnt = bitcnt + 4'h1;
        if (tx_mode) oe <= !txb[4'h7 - bitcnt];
      end
    end
    scl_q = scl;
    sda_q = sda;
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the serial host against the clock-chip model
// Assumes: 200 MHz clock, inputs driven on the falling edge
// Notes: expected read bytes and status are queued by the driver, checked by a monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rtc_host_pkg::*;
  // -----------------------------------------------------------
  // signals
  // -----------------------------------------------------------
  logic CLOCK, RST_B, SCL_OUT, SDA_OUT, SDA_OE, CMD_VALID, CMD_READY, CMD_READ;
  logic [7:0] CMD_WORD, CMD_WDATA, CMD_COUNT;
  logic DONE, NACK, RD_VALID, RD_READY, dev_oe, hold_rd;
  logic [DATA_W-1:0] RD_DATA;
  logic [6:0] dev_id;
  logic [7:0] wbyte;
  wire logic sda_wire;
  int n_errors = 0;
  int cmp_count = 0;
  logic [7:0] exp_rd[$];
  logic exp_nack[$];
  assign sda_wire = !(SDA_OE | dev_oe); // pull-up wins when nobody pulls
  // -----------------------------------------------------------
  // instances
  // -----------------------------------------------------------
  rtc_serial_host dut (.CLOCK(CLOCK), .RST_B(RST_B), .SCL_OUT(SCL_OUT), .SDA_IN(sda_wire),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .CMD_READ(CMD_READ), .CMD_WORD(CMD_WORD), .CMD_WDATA(CMD_WDATA), .CMD_COUNT(CMD_COUNT),
    .DONE(DONE), .NACK(NACK), .RD_VALID(RD_VALID), .RD_READY(RD_READY), .RD_DATA(RD_DATA));
  rtc_dev_model dev (.clk(CLOCK), .scl(SCL_OUT), .sda(sda_wire), .dev_id(dev_id), .oe(dev_oe));
  // clock
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  // -----------------------------------------------------------
  // tasks
  // -----------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one command, waits for ready before and after
  task automatic run_cmd(input logic rd, input logic [7:0] word, input logic [7:0] wdata,
                         input logic [7:0] count, input logic exp_n);
    int k;
    for (k = 0; k < 2000 && CMD_READY !== 1'b1; k++) @(negedge CLOCK);
    if (k == 2000) begin
      n_errors++;
      complete_run();
    end
    CMD_READ = rd;
    CMD_WORD = word;
    CMD_WDATA = wdata;
    CMD_COUNT = count;
    CMD_VALID = 1'b1;
    exp_nack.push_back(exp_n);
    @(negedge CLOCK);
    CMD_VALID = 1'b0;
    for (k = 0; k < 80000 && CMD_READY !== 1'b1; k++) @(negedge CLOCK);
    if (k == 80000) begin
      n_errors++;
      complete_run();
    end
  endtask
  // holds the consumer off until the host stalls the clock, then drains
  task automatic stall_then_drain;
    int k;
    int low;
    low = 0;
    for (k = 0; k < 60000 && low < 600; k++) begin
      @(negedge CLOCK);
      low = (SCL_OUT === 1'b0) ? low + 1 : 0;
    end
    if (low < 600) begin
      n_errors++;
      complete_run();
    end
    check({7'h00, RD_VALID}, 8'h01);
    hold_rd = 1'b0;
  endtask
  // -----------------------------------------------------------
  // monitor: compare each result with the oldest note
  // -----------------------------------------------------------
  always @(posedge CLOCK) begin
    if (RST_B === 1'b1 && RD_VALID === 1'b1 && RD_READY === 1'b1)
      check(RD_DATA, exp_rd.size() ? exp_rd.pop_front() : 8'hXX);
    if (DONE === 1'b1)
      check({7'h00, NACK}, {7'h00, exp_nack.size() ? exp_nack.pop_front() : 1'bx});
  end
  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    RST_B = 1'b0;
    CMD_VALID = 1'b0;
    CMD_READ = 1'b0;
    CMD_WORD = 8'h00;
    CMD_WDATA = 8'h00;
    CMD_COUNT = 8'h00;
    RD_READY = 1'b0;
    hold_rd = 1'b0;
    dev_id = DEV_ID;
    void'($urandom(32'h47DC));
    // random consumer, forked so it shares the seeded generator
    fork
      forever begin
        @(negedge CLOCK);
        RD_READY = hold_rd ? 1'b0 : 1'($urandom);
      end
    join_none
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    check({1'b0, RD_VALID, CMD_READY, DONE, NACK, SDA_OUT, SCL_OUT, SDA_OE}, 8'h02);
    RST_B = 1'b1;
    // single-byte write to the top location
    wbyte = 8'($urandom);
    run_cmd(1'b0, 8'h19, wbyte, 8'h00, 1'b0);
    // wrong identifier: no acknowledge, nothing stored
    dev_id = DEV_ID ^ 7'h40;
    run_cmd(1'b0, 8'h05, 8'hFF, 8'h00, 1'b1);
    dev_id = DEV_ID;
    // nine-byte read across the wrap with the buffer filling up
    exp_rd.push_back(8'h48);
    exp_rd.push_back(wbyte);
    for (int i = 0; i < 7; i++) exp_rd.push_back(8'h30 + 8'(i));
    hold_rd = 1'b1;
    fork
      run_cmd(1'b1, 8'h18, 8'h00, 8'h09, 1'b0);
      stall_then_drain();
    join
    repeat (20) @(negedge CLOCK);
    check(8'(exp_rd.size()), 8'h00);
    check(8'(exp_nack.size()), 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
